// ===== ldfm_pkg.sv
// Purpose: shared constants and types of the loop converter fault monitor
// Assumes: 20 MHz system clock
// Notes: times are kept in their own units, cycle counts derive from them
package ldfm_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int WDOG_TIMEOUT_MS = 1000;
    localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int WDOG_W = 25;
    localparam int BLANK_TIME_US = 30;
    localparam int BLANK_CYCLES = (BLANK_TIME_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int BLANK_W = 10;
    localparam int BIT_CNT_W = 6;
    localparam logic [BIT_CNT_W-1:0] FRAME_BITS_STD = 6'h18;
    localparam logic [BIT_CNT_W-1:0] FRAME_BITS_CRC = 6'h20;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX = 6'h3F;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam int NFLAG = 4;
    localparam int FLAG_T100 = 0;
    localparam int FLAG_T140 = 1;
    localparam int FLAG_WARN = 2;
    localparam int FLAG_CRIT = 3;
    localparam int FW_W = 16;
    localparam int FW_COMM = 15;
    localparam int FW_T140 = 14;
    localparam int FW_T100 = 13;
    localparam int FW_WARN = 12;
    localparam int FW_CRIT = 11;
    localparam int ADC_W_DEF = 8;
    localparam int ADC_W_MAX = 11;

    typedef enum logic [1:0] {
        LDFM_RANGE_4_20 = 2'b00,
        LDFM_RANGE_38_21 = 2'b01,
        LDFM_RANGE_32_24 = 2'b10
    } ldfm_range_e;

    typedef enum logic [1:0] {
        LDFM_ALM_DOWN_3P2 = 2'b00,
        LDFM_ALM_UP_22P8 = 2'b01,
        LDFM_ALM_UP_24 = 2'b10
    } ldfm_alarm_e;

    typedef enum logic [2:0] {
        LDFM_REG_1V8 = 3'b000,
        LDFM_REG_2V5 = 3'b001,
        LDFM_REG_3V0 = 3'b010,
        LDFM_REG_3V3 = 3'b011,
        LDFM_REG_5V0 = 3'b100,
        LDFM_REG_9V0 = 3'b101,
        LDFM_REG_12V0 = 3'b110,
        LDFM_REG_UNDEF = 3'b111
    } ldfm_reg_e;

    typedef enum logic [0:0] {
        LDFM_WD_RUN = 1'b0,
        LDFM_WD_EXPIRED = 1'b1
    } ldfm_wd_e;

    function automatic ldfm_range_e ldfm_decode_range(input logic hi, input logic lo);
        case ({hi, lo})
            2'b00: ldfm_decode_range = LDFM_RANGE_4_20;
            2'b10: ldfm_decode_range = LDFM_RANGE_32_24;
            default: ldfm_decode_range = LDFM_RANGE_38_21;
        endcase
    endfunction

    function automatic ldfm_alarm_e ldfm_decode_alarm(input logic up, input ldfm_range_e rng);
        if (!up) begin
            ldfm_decode_alarm = LDFM_ALM_DOWN_3P2;
        end else if (rng == LDFM_RANGE_32_24) begin
            ldfm_decode_alarm = LDFM_ALM_UP_24;
        end else begin
            ldfm_decode_alarm = LDFM_ALM_UP_22P8;
        end
    endfunction
endpackage

// ===== ldfm_sync.sv
// Purpose: two-stage synchroniser for pins and comparator levels
// Assumes: inputs are asynchronous levels
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module ldfm_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ldfm_sync_s;

    ldfm_sync_s s_q;
    ldfm_sync_s s_d;

    if (W < 1) begin : g_bad_w
        $error("ldfm_sync: W must be at least 1");
    end

    always_comb begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule

// ===== ldfm_hyst.sv
// Purpose: sticky alert flag with separate set and clear levels
// Assumes: set and clear come from synchronised comparators
// Notes: set wins over clear; hold freezes the flag
`timescale 1ns/1ps
module ldfm_hyst (
    input wire logic clk,
    input wire logic rst,
    input wire logic set_lvl,
    input wire logic clr_lvl,
    input wire logic hold,
    output logic flag
);
    typedef struct packed {
        logic flag;
    } ldfm_hyst_s;

    ldfm_hyst_s s_q;
    ldfm_hyst_s s_d;

    always_comb begin
        s_d = s_q;
        if (!hold) begin
            if (set_lvl) begin
                s_d.flag = 1'b1;
            end else if (clr_lvl) begin
                s_d.flag = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag = s_q.flag;
endmodule

// ===== ldfm_top.sv
// Purpose: fault flags, fault pin, straps, on-chip converter control, watchdog
// Assumes: comparator levels, straps and serial pins are asynchronous
// Notes: all outputs are registered; control bits arrive as plain ports
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - two die temperature flags, 100 and 140 degrees
// - upper temperature flag raises fault pin
// - warn flag sets below 0.6, clears above 0.7
// - critical flag sets below 0.3, clears above 0.4
// - critical supply flag raises fault pin
// - range straps decode to three current ranges
// - three regulator straps select seven voltages
// - select bit picks temperature or loop sense
// - measure command powers converter, runs one conversion
// - fault word carries latest conversion result
// - temperature switch blanking; temperature flags in fault word frozen
// - reset loads defaults, holds alarm until programmed
// - alarm level 3.2, 22.8, or 24 mA
// - watchdog on at reset, one second, fault pin
// - direction strap picks upscale or downscale alarm
// - watchdog timeout sets comm flag, forces alarm
module ldfm_top
#(
    parameter int WDOG_LIMIT = ldfm_pkg::WDOG_CYCLES,
    parameter int ADC_W = ldfm_pkg::ADC_W_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic die_over_100,
    input wire logic die_over_140,
    input wire logic loop_below_0p6,
    input wire logic loop_above_0p7,
    input wire logic loop_below_0p3,
    input wire logic loop_above_0p4,
    input wire logic range_strap_low,
    input wire logic range_strap_high,
    input wire logic regulator_strap_bit0,
    input wire logic regulator_strap_bit1,
    input wire logic regulator_strap_bit2,
    input wire logic alarm_dir_strap,
    input wire logic link_sclk,
    input wire logic link_sync_n,
    input wire logic adc_input_select,
    input wire logic adc_power_ctrl,
    input wire logic auto_readback_en,
    input wire logic measure_cmd,
    input wire logic fault_reg_read,
    input wire logic dac_programmed,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_result,
    output logic fault_out,
    output logic [ldfm_pkg::FW_W-1:0] fault_word,
    output logic loop_alarm_force,
    output ldfm_pkg::ldfm_alarm_e alarm_level,
    output ldfm_pkg::ldfm_range_e loop_range,
    output ldfm_pkg::ldfm_reg_e regulator_setting,
    output logic regulator_code_valid,
    output logic adc_start,
    output logic adc_power,
    output logic adc_channel,
    output logic fault_pin_blank,
    output logic watchdog_expired
);
    import ldfm_pkg::*;

    localparam logic [WDOG_W-1:0] WD_LAST = WDOG_W'(WDOG_LIMIT - 1);
    localparam logic [BLANK_W-1:0] BLANK_LAST = BLANK_W'(BLANK_CYCLES - 1);

    if (WDOG_LIMIT < 2 || WDOG_LIMIT > (2 ** WDOG_W) - 1) begin : g_bad_wdog
        $error("ldfm_top: WDOG_LIMIT out of range");
    end
    if (ADC_W < 1 || ADC_W > ADC_W_MAX) begin : g_bad_adc
        $error("ldfm_top: ADC_W out of range");
    end

    typedef struct packed {
        logic [1:0] strap_wait;
        logic strap_taken;
        ldfm_range_e range;
        ldfm_reg_e reg_set;
        logic reg_valid;
        ldfm_alarm_e alarm_lvl;
        logic sclk_prev;
        logic sync_n_prev;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic frame_ok;
        ldfm_wd_e wd_state;
        logic [WDOG_W-1:0] wd_cnt;
        logic comm_loss;
        logic alarm_force;
        logic busy;
        logic adc_start;
        logic adc_power;
        logic adc_chan;
        logic [ADC_W-1:0] result;
        logic blank;
        logic [BLANK_W-1:0] blank_cnt;
        logic fault;
        logic [FW_W-1:0] fault_word;
    } ldfm_top_s;

    ldfm_top_s s_q;
    ldfm_top_s s_d;

    //////////////////////////////////////////////////////////////////////////
    // synchronisers and alert flags
    logic [13:0] raw;
    logic [13:0] syn;
    logic [NFLAG-1:0] flag;
    logic [NFLAG-1:0] set_vec;
    logic [NFLAG-1:0] clr_vec;
    logic [NFLAG-1:0] hold_vec;

    assign raw = {alarm_dir_strap, regulator_strap_bit2, regulator_strap_bit1,
                  regulator_strap_bit0, range_strap_high, range_strap_low,
                  link_sclk, link_sync_n, die_over_140, die_over_100,
                  loop_above_0p7, loop_below_0p6, loop_above_0p4, loop_below_0p3};

    ldfm_sync #(.W(14)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(raw),
        .q(syn)
    );

    logic below03_s, above04_s, below06_s, above07_s, t100_s, t140_s;
    logic sync_n_s, sclk_s;
    assign below03_s = syn[0];
    assign above04_s = syn[1];
    assign below06_s = syn[2];
    assign above07_s = syn[3];
    assign t100_s = syn[4];
    assign t140_s = syn[5];
    assign sync_n_s = syn[6];
    assign sclk_s = syn[7];

    // temperature flags follow the die, frozen while blanking
    assign set_vec = {below03_s, below06_s, t140_s, t100_s};
    assign clr_vec = {above04_s, above07_s, ~t140_s, ~t100_s};
    assign hold_vec = {1'b0, 1'b0, s_q.blank, s_q.blank};

    for (genvar i = 0; i < NFLAG; i++) begin : g_flag
        ldfm_hyst u_hyst (
            .clk(clk),
            .rst(rst),
            .set_lvl(set_vec[i]),
            .clr_lvl(clr_vec[i]),
            .hold(hold_vec[i]),
            .flag(flag[i])
        );
    end

    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        s_d.adc_start = 1'b0;
        s_d.frame_ok = 1'b0;
        s_d.sclk_prev = sclk_s;
        s_d.sync_n_prev = sync_n_s;

        // straps taken once they have settled through the synchroniser
        if (!s_q.strap_taken) begin
            if (s_q.strap_wait == STRAP_SETTLE) begin
                s_d.strap_taken = 1'b1;
                s_d.range = ldfm_decode_range(syn[9], syn[8]);
                s_d.reg_set = ldfm_reg_e'(syn[12:10]);
                s_d.reg_valid = (syn[12:10] != LDFM_REG_UNDEF);
                s_d.alarm_lvl = ldfm_decode_alarm(syn[13],
                    ldfm_decode_range(syn[9], syn[8]));
            end else begin
                s_d.strap_wait = s_q.strap_wait + 2'h1;
            end
        end

        // frame length check on the serial pins
        if (!sync_n_s && s_q.sclk_prev && !sclk_s && s_q.bit_cnt != BIT_CNT_MAX) begin
            s_d.bit_cnt = s_q.bit_cnt + 6'h01;
        end
        if (!sync_n_s && s_q.sync_n_prev) begin
            s_d.bit_cnt = '0;
        end
        if (sync_n_s && !s_q.sync_n_prev) begin
            s_d.frame_ok = (s_q.bit_cnt == FRAME_BITS_STD) || (s_q.bit_cnt == FRAME_BITS_CRC);
        end

        // clears first so that a same-cycle set wins
        if (fault_reg_read) begin
            s_d.comm_loss = 1'b0;
        end
        if (dac_programmed) begin
            s_d.alarm_force = 1'b0;
        end

        // watchdog, stalls after timeout until fault word is read
        case (s_q.wd_state)
            LDFM_WD_RUN: begin
                if (s_q.frame_ok) begin
                    s_d.wd_cnt = '0;
                end else if (s_q.wd_cnt == WD_LAST) begin
                    s_d.wd_state = LDFM_WD_EXPIRED;
                    s_d.comm_loss = 1'b1;
                    s_d.alarm_force = 1'b1;
                end else begin
                    s_d.wd_cnt = s_q.wd_cnt + 25'h0000001;
                end
            end
            LDFM_WD_EXPIRED: begin
                if (fault_reg_read) begin
                    s_d.wd_state = LDFM_WD_RUN;
                    s_d.wd_cnt = '0;
                end
            end
            default: begin
                s_d.wd_state = LDFM_WD_RUN;
            end
        endcase

        // converter control
        if (adc_done) begin
            s_d.result = adc_result;
            s_d.busy = 1'b0;
        end
        if (measure_cmd || (adc_power_ctrl && auto_readback_en && s_q.frame_ok)) begin
            s_d.adc_start = 1'b1;
            s_d.busy = 1'b1;
        end
        s_d.adc_power = adc_power_ctrl | s_d.busy;
        s_d.adc_chan = adc_input_select;

        // blanking after loop-to-temperature switch
        if (s_q.adc_chan && !adc_input_select) begin
            s_d.blank = 1'b1;
            s_d.blank_cnt = BLANK_LAST;
        end else if (s_q.blank) begin
            if (s_q.blank_cnt == '0) begin
                s_d.blank = 1'b0;
            end else begin
                s_d.blank_cnt = s_q.blank_cnt - 10'h001;
            end
        end

        // fault pin ignores the 100 degree and warn flags
        s_d.fault = flag[FLAG_T140] | flag[FLAG_CRIT] | s_q.comm_loss;

        s_d.fault_word = '0;
        s_d.fault_word[FW_COMM] = s_q.comm_loss;
        s_d.fault_word[FW_T140] = flag[FLAG_T140];
        s_d.fault_word[FW_T100] = flag[FLAG_T100];
        s_d.fault_word[FW_WARN] = flag[FLAG_WARN];
        s_d.fault_word[FW_CRIT] = flag[FLAG_CRIT];
        s_d.fault_word[ADC_W-1:0] = s_q.result;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.alarm_force <= 1'b1;
            s_q.sync_n_prev <= 1'b1;
            s_q.wd_state <= LDFM_WD_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs
    assign fault_out = s_q.fault;
    assign fault_word = s_q.fault_word;
    assign loop_alarm_force = s_q.alarm_force;
    assign alarm_level = s_q.alarm_lvl;
    assign loop_range = s_q.range;
    assign regulator_setting = s_q.reg_set;
    assign regulator_code_valid = s_q.reg_valid;
    assign adc_start = s_q.adc_start;
    assign adc_power = s_q.adc_power;
    assign adc_channel = s_q.adc_chan;
    assign fault_pin_blank = s_q.blank;
    assign watchdog_expired = (s_q.wd_state == LDFM_WD_EXPIRED);

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_conv_req;
        measure_cmd;
    endsequence
    sequence s_conv_run;
        s_q.adc_start && s_q.adc_power;
    endsequence
    sequence s_to_temp;
        s_q.adc_chan && !adc_input_select;
    endsequence

    a_pin_hot: assert property (flag[FLAG_T140] |=> fault_out)
        else $error("fault pin low with upper temperature flag");
    a_pin_crit: assert property (flag[FLAG_CRIT] |=> fault_out)
        else $error("fault pin low with critical supply flag");
    a_pin_or: assert property (fault_out ==
        $past(flag[FLAG_T140] | flag[FLAG_CRIT] | s_q.comm_loss))
        else $error("fault pin not the qualifying OR");
    a_t100_track: assert property (t100_s && !s_q.blank |-> ##2 fault_word[FW_T100])
        else $error("100 degree flag missed");
    a_warn_hyst: assert property (flag[FLAG_WARN] && !above07_s |=> flag[FLAG_WARN])
        else $error("warn flag cleared without 0.7 V");
    a_crit_set: assert property (below03_s |=> flag[FLAG_CRIT])
        else $error("critical flag not set");
    a_range_dec: assert property ($rose(s_q.strap_taken) |->
        (loop_range == LDFM_RANGE_4_20) == ($past(syn[9:8]) == 2'h0) &&
        (loop_range == LDFM_RANGE_32_24) == ($past(syn[9:8]) == 2'h2))
        else $error("range decode out of set");
    a_reg_valid: assert property (s_q.strap_taken |->
        regulator_code_valid == (regulator_setting != LDFM_REG_UNDEF))
        else $error("regulator validity wrong");
    a_chan_follow: assert property (adc_input_select |=> adc_channel)
        else $error("converter channel not followed");
    a_conv_start: assert property (s_conv_req |=> s_conv_run)
        else $error("measure command did not start conversion");
    a_result_latch: assert property (adc_done && !measure_cmd |=>
        s_q.result == $past(adc_result) ##1 fault_word[ADC_W-1:0] == $past(adc_result, 2))
        else $error("conversion result not in fault word");
    a_blank_hold: assert property (s_to_temp |=> s_q.blank [*8])
        else $error("blanking window too short");
    a_blank_freeze: assert property (s_q.blank |=> $stable(flag[FLAG_T140]))
        else $error("temperature flag changed while blanking");
    a_alarm_hold: assert property (loop_alarm_force && !dac_programmed
        |=> loop_alarm_force)
        else $error("alarm dropped without programming");
    a_alarm_lvl: assert property (s_q.strap_taken && alarm_level == LDFM_ALM_UP_24
        |-> loop_range == LDFM_RANGE_32_24)
        else $error("24 mA alarm outside wide range");
    a_wdog_trip: assert property (s_q.wd_state == LDFM_WD_RUN
        && s_q.wd_cnt == WD_LAST && !s_q.frame_ok |=> s_q.comm_loss && loop_alarm_force
        ##1 fault_out)
        else $error("watchdog timeout not signalled");
endmodule

// ===== ldfm_host_model.sv
// Purpose: host side of the serial link, frames only
// Assumes: sclk idles high, falls once a bit, 400 ns bit time
// Notes: frame content is not modelled; length decides validity
`timescale 1ns/1ps
module ldfm_host_model (
    output logic link_sclk,
    output logic link_sync_n
);
    initial begin
        link_sclk = 1'b1;
        link_sync_n = 1'b1;
    end
    //////////////////////////////////////////////////////////////////////////
    // one frame of n clock falls; clock stands still between frames
    task automatic send_frame(input int n);
        link_sync_n = 1'b0;
        #200;
        repeat (n) begin
            link_sclk = 1'b0;
            #200;
            link_sclk = 1'b1;
            #200;
        end
        link_sync_n = 1'b1;
        #400;
    endtask
endmodule

// ===== ldfm_top_tb.sv
// Purpose: self-checking bench of the fault monitor top
// Assumes: watchdog shortened to 2000 cycles
// Notes: inputs change 5 ns after the rising edge
`timescale 1ns/1ps
module ldfm_top_tb;
    import ldfm_pkg::*;
    localparam int WD = 2000;
    logic clk, rst, die_over_100, die_over_140, loop_below_0p6, loop_above_0p7;
    logic loop_below_0p3, loop_above_0p4, range_strap_low, range_strap_high, alarm_dir_strap;
    logic regulator_strap_bit0, regulator_strap_bit1, regulator_strap_bit2;
    logic adc_input_select, adc_power_ctrl, auto_readback_en, measure_cmd, fault_reg_read;
    logic dac_programmed, adc_done;
    logic [7:0] adc_result;
    wire link_sclk, link_sync_n;
    logic fault_out, loop_alarm_force, regulator_code_valid, adc_start, adc_power;
    logic adc_channel, fault_pin_blank, watchdog_expired;
    logic [15:0] fault_word;
    ldfm_alarm_e alarm_level, ea;
    ldfm_range_e loop_range, er;
    ldfm_reg_e regulator_setting;
    int err_total, checks, starts, s0;
    logic [5:0] set_v [4] = '{6'h20, 6'h10, 6'h09, 6'h0A};
    logic [5:0] hold_v [4] = '{6'h05, 6'h05, 6'h01, 6'h00};
    logic [4:0] set_e [4] = '{5'h08, 5'h11, 5'h04, 5'h07};
    logic [4:0] hold_e [4] = '{5'h00, 5'h00, 5'h04, 5'h07};

    ldfm_top #(.WDOG_LIMIT(WD), .ADC_W(8)) uut (
        .clk, .rst, .die_over_100, .die_over_140, .loop_below_0p6, .loop_above_0p7,
        .loop_below_0p3, .loop_above_0p4, .range_strap_low, .range_strap_high,
        .regulator_strap_bit0, .regulator_strap_bit1, .regulator_strap_bit2,
        .alarm_dir_strap, .link_sclk, .link_sync_n, .adc_input_select, .adc_power_ctrl,
        .auto_readback_en, .measure_cmd, .fault_reg_read, .dac_programmed, .adc_done,
        .adc_result, .fault_out, .fault_word, .loop_alarm_force, .alarm_level,
        .loop_range, .regulator_setting, .regulator_code_valid, .adc_start, .adc_power,
        .adc_channel, .fault_pin_blank, .watchdog_expired
    );
    ldfm_host_model host (.link_sclk, .link_sync_n);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (adc_start === 1'b1) starts <= starts + 1;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic set_cmp(input logic [5:0] v);
        {die_over_100, die_over_140, loop_below_0p6, loop_above_0p7} = v[5:2];
        {loop_below_0p3, loop_above_0p4} = v[1:0];
    endtask
    task automatic do_reset(input logic [2:0] g, input logic [1:0] r, input logic d);
        {regulator_strap_bit2, regulator_strap_bit1, regulator_strap_bit0} = g;
        {range_strap_high, range_strap_low} = r;
        alarm_dir_strap = d;
        rst = 1'b1;
        tick(6);
        rst = 1'b0;
        tick(8);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        err_total++;
        $display("BAD %0t run timed out", $time);
        finish_test();
    end
    initial begin
        err_total = 0;
        checks = 0;
        starts = 0;
        rst = 1'b1;
        {adc_input_select, adc_power_ctrl, auto_readback_en, measure_cmd} = 4'h0;
        {fault_reg_read, dac_programmed, adc_done} = 3'h0;
        adc_result = 8'h00;
        set_cmp(6'h05);
        {regulator_strap_bit2, regulator_strap_bit1, regulator_strap_bit0} = 3'h0;
        {range_strap_high, range_strap_low, alarm_dir_strap} = 3'h0;
        #5;
        for (int i = 0; i < 8; i++) begin
            do_reset(3'(i), 2'(i), i[2] ^ i[1]);
            case (i[1:0])
                2'h0: er = LDFM_RANGE_4_20;
                2'h2: er = LDFM_RANGE_32_24;
                default: er = LDFM_RANGE_38_21;
            endcase
            if (!(i[2] ^ i[1])) ea = LDFM_ALM_DOWN_3P2;
            else if (er == LDFM_RANGE_32_24) ea = LDFM_ALM_UP_24;
            else ea = LDFM_ALM_UP_22P8;
            chk(16'(loop_range), 16'(er), "range");
            chk(16'(regulator_setting), 16'(i), "regulator");
            chk(16'(regulator_code_valid), 16'(i != 7), "reg valid");
            chk(16'(alarm_level), 16'(ea), "alarm level");
            chk(16'({loop_alarm_force, fault_out}), 16'h2, "power on");
        end
        $display("test straps done");
        for (int k = 0; k < 4; k++) begin
            set_cmp(set_v[k]);
            tick(6);
            chk(16'({fault_word[14:11], fault_out}), 16'(set_e[k]), "set");
            set_cmp(hold_v[k]);
            tick(6);
            chk(16'({fault_word[14:11], fault_out}), 16'(hold_e[k]), "hold");
            set_cmp(6'h05);
            tick(6);
            chk(16'({fault_word[14:11], fault_out}), 16'h0, "clear");
        end
        $display("test flags done");
        do_reset(3'h0, 2'h0, 1'b0);
        adc_input_select = 1'b1;
        tick(3);
        chk(16'(adc_channel), 16'h1, "channel");
        s0 = starts;
        pulse(measure_cmd);
        tick(3);
        chk(16'({starts - s0, adc_power}), 16'h3, "measure");
        adc_result = 8'hA5;
        pulse(adc_done);
        tick(3);
        chk(16'(fault_word[7:0]), 16'hA5, "result");
        chk(16'(adc_power), 16'h0, "power off");
        adc_input_select = 1'b0;
        tick(3);
        chk(16'(fault_pin_blank), 16'h1, "blank on");
        set_cmp(6'h15);
        tick(8);
        chk(16'(fault_word[14]), 16'h0, "frozen");
        tick(620);
        chk(16'({fault_pin_blank, fault_word[14]}), 16'h1, "blank off");
        set_cmp(6'h05);
        adc_power_ctrl = 1'b1;
        tick(2);
        auto_readback_en = 1'b1;
        s0 = starts;
        host.send_frame(24);
        tick(6);
        chk(16'({starts - s0, adc_power}), 16'h3, "auto start");
        {adc_power_ctrl, auto_readback_en} = 2'h0;
        $display("test adc done");
        do_reset(3'h0, 2'h0, 1'b1);
        pulse(dac_programmed);
        tick(2);
        chk(16'(loop_alarm_force), 16'h0, "programmed");
        tick(1400);
        host.send_frame(24);
        tick(1400);
        host.send_frame(32);
        tick(1400);
        chk(16'({watchdog_expired, fault_word[15]}), 16'h0, "kicked");
        host.send_frame(25);
        tick(200);
        chk(16'({watchdog_expired, fault_out}), 16'h0, "not yet");
        tick(400);
        chk(16'({watchdog_expired, fault_word[15], fault_out, loop_alarm_force}), 16'hF,
            "timeout");
        pulse(fault_reg_read);
        tick(3);
        chk(16'({watchdog_expired, fault_word[15]}), 16'h0, "read clears");
        pulse(dac_programmed);
        tick(3);
        chk(16'({loop_alarm_force, fault_out}), 16'h0, "alarm released");
        $display("test watchdog done");
        finish_test();
    end
endmodule
